// ==== inc/oled_pkg.sv ====
// Constants and types shared by the display write port design
package oled_pkg;

  // ----------------------------------------------------------------
  // Bus addresses and control byte layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DEFAULT  = 8'h78;
  localparam logic [7:0] ADDR_ALT      = 8'h7A;
  localparam int         CTRL_CONT_BIT = 7;
  localparam int         CTRL_DC_BIT   = 6;

  // ----------------------------------------------------------------
  // Display memory geometry
  // ----------------------------------------------------------------
  localparam int MEM_BYTES = 2048;
  localparam int PAGE_W    = 4;
  localparam int COL_W     = 7;

  // ----------------------------------------------------------------
  // Command codes (upper nibble) for address setting
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_PAGE   = 4'hB;
  localparam logic [3:0] CMD_COL_LO = 4'h0;
  localparam logic [3:0] CMD_COL_HI = 4'h1;

  // ----------------------------------------------------------------
  // APB register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_PTR    = 8'h0C;
  localparam logic [7:0] REG_MADDR  = 8'h10;
  localparam logic [7:0] REG_MDATA  = 8'h14;
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_STRAP_BIT = 1;
  localparam int         STAT_CNT_LSB   = 16;
  localparam int         CMD_VALID_BIT  = 8;
  localparam int         PTR_PAGE_LSB   = 8;
  localparam logic       CTRL_EN_RST    = 1'b1;

  // ----------------------------------------------------------------
  // Pin synchroniser and strap timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_RST     = 3'h3;
  localparam logic [2:0] STRAP_SETTLE = 3'h5;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SKIP} bus_state_t;
  typedef enum logic [1:0] {ROLE_ADDR, ROLE_CTRL, ROLE_DATA} byte_role_t;

endpackage

// ==== inc/pin_lines_if.sv ====
// Filtered pin levels passed from the synchroniser to the port logic
`timescale 1ns/10ps
interface pin_lines_if;
  logic scl;
  logic sda;
  logic strap;
  modport src (output scl, output sda, output strap);
  modport dst (input scl, input sda, input strap);
endinterface

// ==== hw/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync
  import oled_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [2:0] raw_i,
  pin_lines_if.src        lines
);

  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] flt_r;
  logic [2:0] agree;
  logic [2:0] flt_nxt;

  // A level counts only once stages two and three agree
  assign agree   = ~(s2_r ^ s3_r);
  assign flt_nxt = (agree & s3_r) | (~agree & flt_r);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_r  <= SYNC_RST;
      s2_r  <= SYNC_RST;
      s3_r  <= SYNC_RST;
      flt_r <= SYNC_RST;
    end
    else
    begin
      s1_r  <= raw_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  assign lines.scl   = flt_r[0];
  assign lines.sda   = flt_r[1];
  assign lines.strap = flt_r[2];

endmodule // pin_sync

// ==== hw/oled_i2c_write_port.sv ====
// Two-wire write port with display memory and APB status registers
// Function
// - The device answers only to the write address chosen by the board strap.
// - A control byte with continuation flag zero makes every later byte a data byte.
// - A control byte with continuation flag one is followed by one data byte, then control.
// - The select bit sends following bytes to command registers (0) or display memory (1).
// - Both lines high means the bus is idle.
// - One bit per clock pulse; data changes only while the clock is low.
// - The device acknowledges by pulling the data line low for the bit period.
// - Display memory holds 2048 bytes for up to 128 by 128 pixels.
// - Display memory is 16 pages of 8 pixel rows by 128 columns.
// - Each memory data byte sets 8 vertical pixels at the addressed page and column.
// - Each pixel is one bit, lit or dark.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module oled_i2c_write_port
  import oled_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        addr_sel_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_lines_if lines ();

  pin_sync u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .raw_i    ({addr_sel_i, sda_i, scl_i}),
    .lines    (lines)
  );

  logic             scl_p_r;
  logic             sda_p_r;
  logic [2:0]       strap_cnt_r;
  logic             strap_r;
  bus_state_t       state_r;
  bus_state_t       state_nxt;
  byte_role_t       role_r;
  logic [3:0]       cnt_r;
  logic [7:0]       shift_r;
  logic             cont_r;
  logic             dc_r;
  logic             drive_r;
  logic [PAGE_W-1:0] page_r;
  logic [COL_W-1:0] col_r;
  logic [7:0]       cmd_r;
  logic             cmd_valid_r;
  logic [15:0]      data_cnt_r;
  logic             ctrl_en_r;
  logic [10:0]      maddr_r;
  logic [31:0]      prdata_r;
  logic [7:0]       mem [MEM_BYTES];

  wire scl_rise  = lines.scl & ~scl_p_r;
  wire scl_fall  = ~lines.scl & scl_p_r;
  wire bus_idle  = lines.scl & lines.sda;
  wire start_det = lines.scl & scl_p_r & sda_p_r & ~lines.sda;
  wire stop_det  = lines.scl & scl_p_r & ~sda_p_r & lines.sda;
  wire strap_ok  = (strap_cnt_r == STRAP_SETTLE);

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  wire [7:0] my_addr   = strap_r ? ADDR_ALT : ADDR_DEFAULT;
  wire       byte_done = (state_r == ST_RECV) && scl_fall && (cnt_r == 4'h8);
  wire       addr_hit  = (shift_r == my_addr) && ctrl_en_r && strap_ok;
  wire       accept    = byte_done && ((role_r != ROLE_ADDR) || addr_hit);
  wire       is_addr   = accept && (role_r == ROLE_ADDR);
  wire       is_ctrl   = byte_done && (role_r == ROLE_CTRL);
  wire       is_data   = byte_done && (role_r == ROLE_DATA);
  wire       mem_wr    = is_data && dc_r;
  wire       cmd_wr    = is_data && !dc_r;
  wire [3:0] cmd_hi    = shift_r[7:4];
  wire       set_page  = cmd_wr && (cmd_hi == CMD_PAGE);
  wire       set_col_l = cmd_wr && (cmd_hi == CMD_COL_LO);
  wire       set_col_h = cmd_wr && (cmd_hi == CMD_COL_HI);
  wire [10:0] mem_idx  = {page_r, col_r};

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_setup = psel_i & ~penable_i;
  wire apb_acc   = psel_i & penable_i;
  wire sel_ctrl  = (paddr_i == REG_CTRL);
  wire sel_stat  = (paddr_i == REG_STATUS);
  wire sel_cmd   = (paddr_i == REG_CMD);
  wire sel_ptr   = (paddr_i == REG_PTR);
  wire sel_maddr = (paddr_i == REG_MADDR);
  wire sel_mdata = (paddr_i == REG_MDATA);
  wire apb_map   = sel_ctrl | sel_stat | sel_cmd | sel_ptr | sel_maddr | sel_mdata;
  wire apb_wr    = apb_acc & pwrite_i;
  wire wr_ctrl   = apb_wr & sel_ctrl;
  wire wr_cmd    = apb_wr & sel_cmd;
  wire wr_ptr    = apb_wr & sel_ptr;
  wire wr_maddr  = apb_wr & sel_maddr;
  wire busy      = (state_r != ST_IDLE);

  wire [31:0] rd_ctrl  = {31'h0, ctrl_en_r};
  wire [31:0] rd_stat  = {data_cnt_r, 14'h0, strap_r, busy};
  wire [31:0] rd_cmd   = {23'h0, cmd_valid_r, cmd_r};
  wire [31:0] rd_ptr   = {20'h0, page_r, 1'b0, col_r};
  wire [31:0] rd_maddr = {21'h0, maddr_r};
  wire [31:0] rd_mdata = {24'h0, mem[maddr_r]};
  wire [31:0] rd_word  = ({32{sel_ctrl}}  & rd_ctrl)  |
                         ({32{sel_stat}}  & rd_stat)  |
                         ({32{sel_cmd}}   & rd_cmd)   |
                         ({32{sel_ptr}}   & rd_ptr)   |
                         ({32{sel_maddr}} & rd_maddr) |
                         ({32{sel_mdata}} & rd_mdata);

  // Zero wait states; read data is captured during setup
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & ~apb_map;
  assign prdata_o  = prdata_r;

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    if (stop_det)
      state_nxt = ST_IDLE;
    else if (start_det)
      state_nxt = ST_RECV;
    else
    begin
      unique case (state_r)
        ST_IDLE: state_nxt = ST_IDLE;
        ST_RECV:
        begin
          if (byte_done)
            state_nxt = accept ? ST_ACK : ST_SKIP;
        end
        ST_ACK:
        begin
          if (scl_fall)
            state_nxt = ST_RECV;
        end
        ST_SKIP: state_nxt = ST_SKIP;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      state_r <= ST_IDLE;
      drive_r <= 1'b0;
    end
    else
    begin
      scl_p_r <= lines.scl;
      sda_p_r <= lines.sda;
      state_r <= state_nxt;
      drive_r <= (state_nxt == ST_ACK);
    end
  end

  // Strap is read only after the filter has settled; the filter needs four edges
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_cnt_r <= 3'h0;
      strap_r     <= 1'b0;
    end
    else if (!strap_ok)
    begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == STRAP_SETTLE - 3'h1)
        strap_r <= lines.strap;
    end
  end

  // ----------------------------------------------------------------
  // Bit and byte sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
    end
    else if (start_det || (state_r == ST_ACK && scl_fall))
      cnt_r   <= 4'h0;
    else if (state_r == ST_RECV && scl_rise)
    begin
      cnt_r   <= cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], lines.sda};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      role_r <= ROLE_ADDR;
      cont_r <= 1'b0;
      dc_r   <= 1'b0;
    end
    else if (start_det)
      role_r <= ROLE_ADDR;
    else if (is_addr)
      role_r <= ROLE_CTRL;
    else if (is_ctrl)
    begin
      role_r <= ROLE_DATA;
      cont_r <= shift_r[CTRL_CONT_BIT];
      dc_r   <= shift_r[CTRL_DC_BIT];
    end
    else if (is_data)
      role_r <= cont_r ? ROLE_CTRL : ROLE_DATA;
  end

  // Acknowledge pulls low; otherwise the pin is released
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~drive_r;

  // ----------------------------------------------------------------
  // Command and display memory paths
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (mem_wr)
      mem[mem_idx] <= shift_r;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      page_r <= '0;
      col_r  <= '0;
    end
    else if (set_page)
      page_r <= shift_r[PAGE_W-1:0];
    else if (set_col_l)
      col_r[3:0] <= shift_r[3:0];
    else if (set_col_h)
      col_r[6:4] <= shift_r[2:0];
    else if (mem_wr)
      col_r <= col_r + 7'h1;
    else if (wr_ptr)
    begin
      page_r <= pwdata_i[PTR_PAGE_LSB+:PAGE_W];
      col_r  <= pwdata_i[COL_W-1:0];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_r       <= 8'h00;
      cmd_valid_r <= 1'b0;
      data_cnt_r  <= 16'h0000;
    end
    else
    begin
      if (cmd_wr)
        cmd_r <= shift_r;
      if (cmd_wr)
        cmd_valid_r <= 1'b1;
      else if (wr_cmd && pwdata_i[CMD_VALID_BIT])
        cmd_valid_r <= 1'b0;
      if (is_data)
        data_cnt_r <= data_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_en_r <= CTRL_EN_RST;
      maddr_r   <= 11'h000;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_en_r <= pwdata_i[CTRL_EN_BIT];
      if (wr_maddr)
        maddr_r <= pwdata_i[10:0];
      if (apb_setup)
        prdata_r <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_addr_match: assert property (byte_done && role_r == ROLE_ADDR
    && shift_r != ADDR_DEFAULT && shift_r != ADDR_ALT |=> state_r == ST_SKIP)
    else $error("foreign address not refused");

  a_final_ctrl: assert property (is_ctrl && !shift_r[CTRL_CONT_BIT]
    |=> role_r == ROLE_DATA && !cont_r)
    else $error("final control byte not followed by data role");

  a_cont_ctrl: assert property (is_data && cont_r |=> role_r == ROLE_CTRL)
    else $error("continued data byte not followed by control role");

  a_cmd_route: assert property (cmd_wr |=> cmd_r == $past(shift_r) && cmd_valid_r)
    else $error("command byte not captured");

  a_idle_release: assert property (state_r == ST_IDLE |-> sda_oe_n_o)
    else $error("data line driven while idle");

  a_drive_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_p_r)
    else $error("data line changed while clock high");

  a_ack_pull: assert property (accept ##1 !scl_fall |-> !sda_oe_n_o && !sda_o)
    else $error("acknowledge not driven low");

  a_ack_every: assert property (accept |=> state_r == ST_ACK ##1 !sda_oe_n_o)
    else $error("accepted byte not acknowledged");

  a_mem_write: assert property (mem_wr |=> mem[$past(mem_idx)] == $past(shift_r))
    else $error("display byte not stored at pointer");

  a_col_advance: assert property (mem_wr && !wr_ptr |=> col_r == $past(col_r) + 7'h1)
    else $error("column did not advance after display byte");

  c_mem_byte: cover property (mem_wr);
  c_cmd_byte: cover property (cmd_wr);
  c_addr_miss: cover property (byte_done && role_r == ROLE_ADDR && !addr_hit);
  c_stop_seen: cover property (stop_det && busy);

endmodule // oled_i2c_write_port

// ==== verif/host_master_model.sv ====
// Behavioural two-wire bus master that writes to the display port
`timescale 1ns/10ps
module host_master_model
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ----------------------------------------------------------------
  // Idle: clock stands high, data released to the pull-up
  // ----------------------------------------------------------------
  initial
  begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Low phase 6 clk, high 2 clk: the long low phase leaves room for the
  // filter delay before the device releases its acknowledge pull.
  task automatic clock_bit();
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(2);
    scl_o <= 1'b0;
  endtask

  task automatic start_cond();
    sda_pull_o <= 1'b1;
    wait_clk(4);
    scl_o <= 1'b0;
    wait_clk(3);
  endtask

  task automatic stop_cond();
    sda_pull_o <= 1'b1;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(3);
    sda_pull_o <= 1'b0;
    wait_clk(6);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull_o <= ~b[i];
      clock_bit();
      wait_clk(3);
    end
    sda_pull_o <= 1'b0;
    wait_clk(3);
    scl_o <= 1'b1;
    wait_clk(1);
    ack = (sda_i === 1'b0);
    @(posedge clk_i);
    scl_o <= 1'b0;
    wait_clk(3);
  endtask
endmodule // host_master_model

// ==== verif/tb_oled_i2c_write_port.sv ====
// Self-checking testbench for the display write port
`timescale 1ns/10ps
module tb_oled_i2c_write_port;
  import oled_pkg::*;

  logic        clk_i;
  logic        resetn_i;
  logic        addr_sel;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sda_out;
  logic        sda_oe_n;
  logic        scl;
  logic        host_pull;
  logic        sda_w;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          samples_checked;

  // Open-drain wire with pull-up: low while either party pulls
  assign sda_w = (host_pull || (sda_oe_n === 1'b0 && sda_out === 1'b0)) ? 1'b0 : 1'b1;

  oled_i2c_write_port dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w),
    .addr_sel_i(addr_sel), .sda_o(sda_out), .sda_oe_n_o(sda_oe_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr)
  );

  host_master_model host (
    .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(host_pull)
  );

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // APB master; waits on pready, only the watchdog bounds the wait
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic mem_chk(input logic [31:0] idx, input logic [7:0] exp);
    apb(1'b1, REG_MADDR, idx);
    rd_chk(REG_MDATA, {24'h00_0000, exp});
  endtask

  // Whole write frame; a refused address is followed straight by stop
  task automatic frame(input logic [7:0] q[$], input logic ok);
    logic ack;
    host.start_cond();
    foreach (q[i])
    begin
      host.send_byte(q[i], ack);
      check({31'h0, ack}, {31'h0, ok});
      if (!ok)
        break;
    end
    host.stop_cond();
  endtask

  task automatic do_reset(input logic sel);
    addr_sel <= sel;
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    logic       ack;
    logic [7:0] cmd_seq [3];
    cmd_seq = '{8'hB3, 8'h05, 8'h12};
    n_mismatch      = 0;
    samples_checked = 0;
    resetn_i = 1'b0;
    addr_sel = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    do_reset(1'b0);

    rd_chk(REG_CTRL, 32'h0000_0001);
    rd_chk(REG_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    check({31'h0, pready}, 32'h0000_0001);
    $display("test reset_values done");

    // Command bytes set page 3 and column 0x25
    host.start_cond();
    host.send_byte(ADDR_DEFAULT, ack);
    check({31'h0, ack}, 32'h0000_0001);
    rd_chk(REG_STATUS, 32'h0000_0001);
    host.send_byte(8'h00, ack);
    check({31'h0, ack}, 32'h0000_0001);
    foreach (cmd_seq[i])
    begin
      host.send_byte(cmd_seq[i], ack);
      check({31'h0, ack}, 32'h0000_0001);
    end
    host.stop_cond();
    rd_chk(REG_PTR, 32'h0000_0325);
    rd_chk(REG_CMD, 32'h0000_0112);
    apb(1'b1, REG_CMD, 32'h0000_0100);
    rd_chk(REG_CMD, 32'h0000_0012);
    $display("test command_path done");

    // Memory bytes at the last place, with column wrap
    apb(1'b1, REG_PTR, 32'h0000_0F7F);
    frame({8'h78, 8'hC0, 8'hAA, 8'h40, 8'h55, 8'h0F}, 1'b1);
    mem_chk(32'd2047, 8'hAA);
    mem_chk(32'd1920, 8'h55);
    mem_chk(32'd1921, 8'h0F);
    rd_chk(REG_PTR, 32'h0000_0F02);
    rd_chk(REG_CMD, 32'h0000_0012);
    rd_chk(REG_STATUS, 32'h0006_0000);
    $display("test memory_path done");

    // Refused addresses and disabled port
    frame({8'h7A, 8'h40, 8'h11}, 1'b0);
    frame({8'h79, 8'h40, 8'h11}, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    frame({8'h78, 8'h40, 8'h11}, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    rd_chk(REG_PTR, 32'h0000_0F02);
    $display("test refusals done");

    // Alternative strap after a second reset
    do_reset(1'b1);
    rd_chk(REG_STATUS, 32'h0000_0002);
    frame({8'h78, 8'h40, 8'h22}, 1'b0);
    apb(1'b1, REG_PTR, 32'h0000_0210);
    frame({8'h7A, 8'h80, 8'hB5, 8'h40, 8'h22}, 1'b1);
    mem_chk(32'd656, 8'h22);
    $display("test alt_address done");
    summarize();
  end

  // Whole run needs about 1700 clk; allow over ten times that
  initial
  begin
    #1_000_000;
    n_mismatch++;
    summarize();
  end
endmodule // tb_oled_i2c_write_port
